// file: verilog/atd_pkg.sv
/*
 Package for the analogue trip discriminator: widths, mode codes, register offsets, reset values, timing.
 Assumes a 25 MHz system clock.
*/
`default_nettype none
package atd_pkg;
   localparam int          NUM_CH        = 8;
   localparam int          CH_W          = 3;
   localparam int          SAMP_W        = 16;
   localparam int          DLY_W         = 8;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;

   typedef enum logic [1:0] {
      ATD_NORM_SWITCH = 2'h0,
      ATD_INV_SWITCH  = 2'h1,
      ATD_NORM_WINDOW = 2'h3,
      ATD_INV_WINDOW  = 2'h2
   } atd_mode_e;

   localparam longint      CLK_HZ        = 25000000;
   localparam longint      TICK_SEC      = 1;
   localparam int          TICK_CYC      = int'(CLK_HZ * TICK_SEC);
   localparam int          TICK_W        = 25;
   localparam logic [7:0]  SAMP_INT_RST  = 8'h01;

   // Per-channel registers sit at CH_BASE + channel * CH_STRIDE
   localparam logic [7:0]  OFF_CH_BASE   = 8'h00;
   localparam logic [7:0]  CH_STRIDE     = 8'h10;
   localparam logic [3:0]  OFF_LOWER     = 4'h0;
   localparam logic [3:0]  OFF_UPPER     = 4'h4;
   localparam logic [3:0]  OFF_HYST      = 4'h8;
   localparam logic [3:0]  OFF_CFG       = 4'hc;
   localparam logic [7:0]  OFF_FLAGS     = 8'h80;
   localparam logic [7:0]  OFF_STATUS    = 8'h84;
   localparam logic [7:0]  OFF_MASK      = 8'h88;
   localparam logic [7:0]  OFF_SAMP_INT  = 8'h8c;
   localparam int          CFG_MODE_LSB  = 0;
   localparam int          CFG_DLY_LSB   = 8;
   localparam logic [SAMP_W-1:0] LEVEL_RST = 16'h0000;
endpackage
`default_nettype wire

// file: verilog/atd_tick.sv
/*
 One-second tick generator and sample-interval divider.
 Assumes a free-running clk_in at the package rate.
*/
`default_nettype none
module atd_tick
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [7:0] interval_in,
   output logic            sec_tick_out,
   output logic            samp_tick_out
);
   import atd_pkg::*;

   logic [TICK_W-1:0] cyc_r, cyc_nxt;
   logic [7:0]        sec_r, sec_nxt;
   logic              sec_tick_r, sec_tick_nxt;
   logic              samp_tick_r, samp_tick_nxt;

   // R12: one second tick
   always_comb begin
      cyc_nxt       = cyc_r + TICK_W'(1);
      sec_tick_nxt  = 1'b0;
      sec_nxt       = sec_r;
      samp_tick_nxt = 1'b0;
      if (cyc_r == TICK_W'(TICK_CYC - 1)) begin
         cyc_nxt      = '0;
         sec_tick_nxt = 1'b1;
         // R11: configurable sample interval
         if (sec_r + 8'h01 >= interval_in) begin
            sec_nxt       = 8'h00;
            samp_tick_nxt = 1'b1;
         end else begin
            sec_nxt = sec_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cyc_r       <= '0;
         sec_r       <= 8'h00;
         sec_tick_r  <= 1'b0;
         samp_tick_r <= 1'b0;
      end else begin
         cyc_r       <= cyc_nxt;
         sec_r       <= sec_nxt;
         sec_tick_r  <= sec_tick_nxt;
         samp_tick_r <= samp_tick_nxt;
      end
   end

   assign sec_tick_out  = sec_tick_r;
   assign samp_tick_out = samp_tick_r;
endmodule
`default_nettype wire

// file: verilog/atd_chan.sv
/*
 One discriminator channel: mode comparison, hysteresis, qualifying delay.
 Assumes a sample strobe and a one-second tick from the same clock.
*/
`default_nettype none
module atd_chan
(
   input  wire logic                              clk_in,
   input  wire logic                              rst_in,
   input  wire logic                              samp_valid_in,
   input  wire logic signed [atd_pkg::SAMP_W-1:0] sample_in,
   input  wire logic signed [atd_pkg::SAMP_W-1:0] lower_in,
   input  wire logic signed [atd_pkg::SAMP_W-1:0] upper_in,
   input  wire logic signed [atd_pkg::SAMP_W-1:0] hyst_in,
   input  wire atd_pkg::atd_mode_e                mode_in,
   input  wire logic [atd_pkg::DLY_W-1:0]         delay_in,
   input  wire logic                              sec_tick_in,
   output logic                                   flag_out
);
   import atd_pkg::*;

   logic             flag_r, flag_nxt;
   logic [DLY_W-1:0] cnt_r, cnt_nxt;
   logic             qual_r, qual_nxt;
   logic             set_c, clr_c;
   logic signed [SAMP_W:0] s, lo, up, lo_p, lo_m, up_p, up_m;

   // R13: one signed scale, strict tests
   always_comb begin
      s    = {sample_in[SAMP_W-1], sample_in};
      lo   = {lower_in[SAMP_W-1], lower_in};
      up   = {upper_in[SAMP_W-1], upper_in};
      lo_p = lo + {hyst_in[SAMP_W-1], hyst_in};
      lo_m = lo - {hyst_in[SAMP_W-1], hyst_in};
      up_p = up + {hyst_in[SAMP_W-1], hyst_in};
      up_m = up - {hyst_in[SAMP_W-1], hyst_in};
      // R1: mode select
      case (mode_in)
         ATD_NORM_SWITCH: begin
            // R2: above upper, below lower
            set_c = s > up;
            clr_c = s < lo;
         end
         ATD_INV_SWITCH: begin
            // R3: below lower, above upper
            set_c = s < lo;
            clr_c = s > up;
         end
         ATD_NORM_WINDOW: begin
            // R4: outside window sets
            set_c = (s > up) || (s < lo);
            // R5: inside shrunk window
            clr_c = (s < up_m) && (s > lo_p);
         end
         ATD_INV_WINDOW: begin
            // R6: inside window sets
            set_c = (s > lo) && (s < up);
            // R7: outside widened window
            clr_c = (s > up_p) || (s < lo_m);
         end
         default: begin
            set_c = 1'b0;
            clr_c = 1'b0;
         end
      endcase
   end

   always_comb begin
      flag_nxt = flag_r;
      cnt_nxt  = cnt_r;
      qual_nxt = qual_r;
      if (samp_valid_in) begin
         if (!set_c) begin
            // R9: restart delay
            cnt_nxt  = '0;
            qual_nxt = 1'b0;
            if (clr_c) begin
               flag_nxt = 1'b0;
            end
         end else begin
            qual_nxt = 1'b1;
            // R8: full delay held, R10: zero means at once
            if (cnt_r >= delay_in) begin
               flag_nxt = 1'b1;
            end
         end
      end else if (sec_tick_in && qual_r && !flag_r) begin
         // R12: saturating seconds count
         if (cnt_r != '1) begin
            cnt_nxt = cnt_r + DLY_W'(1);
         end
      end
   end

   // R12: cleared on reset
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flag_r <= 1'b0;
         cnt_r  <= '0;
         qual_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
         cnt_r  <= cnt_nxt;
         qual_r <= qual_nxt;
      end
   end

   assign flag_out = flag_r;
endmodule
`default_nettype wire

// file: verilog/atd_top.sv
/*
 Analogue trip discriminator: eight channels with register port and interrupt.
 Assumes samples arrive from the sampler on clk_in as a channel number, value and strobe.
*/
// Chosen here: the register offsets and the plain strobed port.
// Contract
// R1: Four modes per input: normal switch, inverted switch, normal window, inverted window.
// R2: Normal switch sets above upper, clears below lower, else holds.
// R3: Inverted switch sets below lower, clears above upper, else holds.
// R4: Normal window sets when above upper or below lower.
// R5: Normal window clears when below upper-hyst and above lower+hyst.
// R6: Inverted window sets when strictly between lower and upper.
// R7: Inverted window clears above upper+hyst or below lower-hyst.
// R8: Flag sets only after set condition held for whole delay.
// R9: Any sample without set condition restarts delay from zero.
// R10: Delay is 0 to 255 seconds; zero means no delay.
// R11: Evaluated per sample; sample interval configurable, default one second.
// R12: Delay counts one-second ticks, saturates, clears with flag on reset.
// R13: Levels, hysteresis and samples share signed scale; comparisons strict.
`default_nettype none
module atd_top
(
   input  wire logic                              clk_in,
   input  wire logic                              rst_in,
   input  wire logic                              samp_valid_in,
   input  wire logic [atd_pkg::CH_W-1:0]          samp_ch_in,
   input  wire logic signed [atd_pkg::SAMP_W-1:0] samp_data_in,
   output logic                                   samp_req_out,
   output logic [atd_pkg::NUM_CH-1:0]             flag_out,
   input  wire logic [atd_pkg::ADDR_W-1:0]        addr_in,
   input  wire logic [atd_pkg::DATA_W-1:0]        wdata_in,
   input  wire logic                              wr_in,
   input  wire logic                              rd_in,
   output logic [atd_pkg::DATA_W-1:0]             rdata_out,
   output logic                                   irq_out
);
   import atd_pkg::*;

   logic [SAMP_W-1:0] lower_r [NUM_CH];
   logic [SAMP_W-1:0] upper_r [NUM_CH];
   logic [SAMP_W-1:0] hyst_r  [NUM_CH];
   logic [1:0]        mode_r  [NUM_CH];
   logic [DLY_W-1:0]  dly_r   [NUM_CH];
   logic [SAMP_W-1:0] lower_nxt [NUM_CH];
   logic [SAMP_W-1:0] upper_nxt [NUM_CH];
   logic [SAMP_W-1:0] hyst_nxt  [NUM_CH];
   logic [1:0]        mode_nxt  [NUM_CH];
   logic [DLY_W-1:0]  dly_nxt   [NUM_CH];
   logic [7:0]        samp_int_r, samp_int_nxt;
   logic [NUM_CH-1:0] status_r, status_nxt;
   logic [NUM_CH-1:0] mask_r, mask_nxt;
   logic [NUM_CH-1:0] flag_d_r;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [NUM_CH-1:0] flags;
   logic              sec_tick, samp_tick;

   function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int c, input logic [3:0] off);
      ch_hit = (a == 8'(OFF_CH_BASE + 8'(c) * CH_STRIDE + {4'h0, off}));
   endfunction

   atd_tick u_tick (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .interval_in   (samp_int_r),
      .sec_tick_out  (sec_tick),
      .samp_tick_out (samp_tick)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         atd_chan u_chan (
            .clk_in        (clk_in),
            .rst_in        (rst_in),
            .samp_valid_in (samp_valid_in && (samp_ch_in == CH_W'(g))),
            .sample_in     (samp_data_in),
            .lower_in      (lower_r[g]),
            .upper_in      (upper_r[g]),
            .hyst_in       (hyst_r[g]),
            .mode_in       (atd_mode_e'(mode_r[g])),
            .delay_in      (dly_r[g]),
            .sec_tick_in   (sec_tick),
            .flag_out      (flags[g])
         );
      end
   endgenerate

   // Register writes
   always_comb begin
      samp_int_nxt = samp_int_r;
      mask_nxt     = mask_r;
      for (int c = 0; c < NUM_CH; c++) begin
         lower_nxt[c] = lower_r[c];
         upper_nxt[c] = upper_r[c];
         hyst_nxt[c]  = hyst_r[c];
         mode_nxt[c]  = mode_r[c];
         dly_nxt[c]   = dly_r[c];
         if (wr_in && ch_hit(addr_in, c, OFF_LOWER)) begin
            lower_nxt[c] = wdata_in[SAMP_W-1:0];
         end
         if (wr_in && ch_hit(addr_in, c, OFF_UPPER)) begin
            upper_nxt[c] = wdata_in[SAMP_W-1:0];
         end
         if (wr_in && ch_hit(addr_in, c, OFF_HYST)) begin
            hyst_nxt[c] = wdata_in[SAMP_W-1:0];
         end
         // R1: mode per input
         if (wr_in && ch_hit(addr_in, c, OFF_CFG)) begin
            mode_nxt[c] = wdata_in[CFG_MODE_LSB +: 2];
            // R10: delay 0 to 255
            dly_nxt[c]  = wdata_in[CFG_DLY_LSB +: DLY_W];
         end
      end
      // R11: sample interval
      if (wr_in && addr_in == OFF_SAMP_INT) begin
         samp_int_nxt = wdata_in[7:0];
      end
      if (wr_in && addr_in == OFF_MASK) begin
         mask_nxt = wdata_in[NUM_CH-1:0];
      end
   end

   // Status sticky on flag change; read clears, set wins
   always_comb begin
      status_nxt = status_r;
      if (rd_in && addr_in == OFF_STATUS) begin
         status_nxt = '0;
      end
      status_nxt = status_nxt | (flags ^ flag_d_r);
   end

   // Read data, one cycle later
   always_comb begin
      rdata_nxt = '0;
      if (rd_in) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (ch_hit(addr_in, c, OFF_LOWER)) begin
               rdata_nxt = {16'h0000, lower_r[c]};
            end
            if (ch_hit(addr_in, c, OFF_UPPER)) begin
               rdata_nxt = {16'h0000, upper_r[c]};
            end
            if (ch_hit(addr_in, c, OFF_HYST)) begin
               rdata_nxt = {16'h0000, hyst_r[c]};
            end
            if (ch_hit(addr_in, c, OFF_CFG)) begin
               rdata_nxt = {16'h0000, dly_r[c], 6'h00, mode_r[c]};
            end
         end
         case (addr_in)
            OFF_FLAGS:    rdata_nxt = {24'h000000, flags};
            OFF_STATUS:   rdata_nxt = {24'h000000, status_r};
            OFF_MASK:     rdata_nxt = {24'h000000, mask_r};
            OFF_SAMP_INT: rdata_nxt = {24'h000000, samp_int_r};
            default:      ;
         endcase
      end
   end

   // R12: synchronous reset of configuration and state
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int c = 0; c < NUM_CH; c++) begin
            lower_r[c] <= LEVEL_RST;
            upper_r[c] <= LEVEL_RST;
            hyst_r[c]  <= LEVEL_RST;
            mode_r[c]  <= 2'h0;
            dly_r[c]   <= 8'h00;
         end
         samp_int_r <= SAMP_INT_RST;
         status_r   <= '0;
         mask_r     <= '0;
         flag_d_r   <= '0;
         rdata_r    <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            lower_r[c] <= lower_nxt[c];
            upper_r[c] <= upper_nxt[c];
            hyst_r[c]  <= hyst_nxt[c];
            mode_r[c]  <= mode_nxt[c];
            dly_r[c]   <= dly_nxt[c];
         end
         samp_int_r <= samp_int_nxt;
         status_r   <= status_nxt;
         mask_r     <= mask_nxt;
         flag_d_r   <= flags;
         rdata_r    <= rdata_nxt;
      end
   end

   // R11: request a sample sweep each interval
   assign samp_req_out = samp_tick;
   assign flag_out     = flags;
   assign rdata_out    = rdata_r;
   assign irq_out      = |(status_r & mask_r);
endmodule
`default_nettype wire

// file: testbench/atd_top_checker.sv
/*
 Port checker for the trip discriminator.
 Assumes it is bound onto atd_top with one clock and a synchronous reset.
*/
`default_nettype none
module atd_top_checker
(
   input wire logic                              clk_in,
   input wire logic                              rst_in,
   input wire logic                              samp_valid_in,
   input wire logic [atd_pkg::CH_W-1:0]          samp_ch_in,
   input wire logic signed [atd_pkg::SAMP_W-1:0] samp_data_in,
   input wire logic                              samp_req_out,
   input wire logic [atd_pkg::NUM_CH-1:0]        flag_out,
   input wire logic [atd_pkg::ADDR_W-1:0]        addr_in,
   input wire logic [atd_pkg::DATA_W-1:0]        wdata_in,
   input wire logic                              wr_in,
   input wire logic                              rd_in,
   input wire logic [atd_pkg::DATA_W-1:0]        rdata_out,
   input wire logic                              irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import atd_pkg::*;

   logic signed [SAMP_W-1:0] up_r  [NUM_CH];
   logic signed [SAMP_W-1:0] lo_r  [NUM_CH];
   logic [15:0]              cfg_r [NUM_CH];

   // Shadow of channel levels and config
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         up_r  <= '{default: '0};
         lo_r  <= '{default: '0};
         cfg_r <= '{default: '0};
      end else if (wr_in && !addr_in[7]) begin
         if (addr_in[3:0] == OFF_UPPER) up_r[addr_in[6:4]] <= wdata_in[15:0];
         if (addr_in[3:0] == OFF_LOWER) lo_r[addr_in[6:4]] <= wdata_in[15:0];
         if (addr_in[3:0] == OFF_CFG) cfg_r[addr_in[6:4]] <= wdata_in[15:0];
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_reset_clear: assert property (
      $fell(rst_in) |-> flag_out == '0 && !irq_out) else $error("Outputs not clear after reset");
   a_flag_cause: assert property (
      $changed(flag_out) && !$past(rst_in) |-> $past(samp_valid_in)) else $error("Flag moved without sample");
   a_one_chan: assert property (
      $changed(flag_out) && !$past(rst_in) |-> (flag_out ^ $past(flag_out)) == (NUM_CH'(1) << $past(samp_ch_in)))
      else $error("Flag of wrong channel moved");
   a_nsw_set: assert property (
      samp_valid_in && cfg_r[samp_ch_in] == 16'h0000 && samp_data_in > up_r[samp_ch_in]
      |=> flag_out[$past(samp_ch_in)]) else $error("Normal switch did not set");
   a_nsw_clear: assert property (
      samp_valid_in && cfg_r[samp_ch_in][1:0] == 2'h0 && samp_data_in < lo_r[samp_ch_in]
      |=> !flag_out[$past(samp_ch_in)]) else $error("Normal switch did not clear");
   a_isw_set: assert property (
      samp_valid_in && cfg_r[samp_ch_in] == 16'h0001 && samp_data_in < lo_r[samp_ch_in]
      |=> flag_out[$past(samp_ch_in)]) else $error("Inverted switch did not set");
   a_nwin_set: assert property (
      samp_valid_in && cfg_r[samp_ch_in] == 16'h0003
      && (samp_data_in > up_r[samp_ch_in] || samp_data_in < lo_r[samp_ch_in])
      |=> flag_out[$past(samp_ch_in)]) else $error("Normal window did not set");
   a_iwin_set: assert property (
      samp_valid_in && cfg_r[samp_ch_in] == 16'h0002
      && samp_data_in > lo_r[samp_ch_in] && samp_data_in < up_r[samp_ch_in]
      |=> flag_out[$past(samp_ch_in)]) else $error("Inverted window did not set");
   a_req_pulse: assert property (
      samp_req_out |=> !samp_req_out) else $error("Sample request longer than one cycle");
   a_req_quiet: assert property (
      $fell(rst_in) |-> !samp_req_out [*8]) else $error("Sample request too soon after reset");
   a_rdata_idle: assert property (
      !$past(rd_in) |-> rdata_out == '0) else $error("Read data without read");
   a_flags_read: assert property (
      rd_in && addr_in == OFF_FLAGS |=> rdata_out == DATA_W'($past(flag_out))) else $error("Flags read wrong");
endmodule

bind atd_top atd_top_checker u_chk (
   .clk_in        (clk_in),
   .rst_in        (rst_in),
   .samp_valid_in (samp_valid_in),
   .samp_ch_in    (samp_ch_in),
   .samp_data_in  (samp_data_in),
   .samp_req_out  (samp_req_out),
   .flag_out      (flag_out),
   .addr_in       (addr_in),
   .wdata_in      (wdata_in),
   .wr_in         (wr_in),
   .rd_in         (rd_in),
   .rdata_out     (rdata_out),
   .irq_out       (irq_out)
);
`default_nettype wire

// file: testbench/atd_sampler.sv
/*
 Model of the analogue sampler feeding the discriminator.
 Assumes the bench calls send for each sample.
*/
`default_nettype none
module atd_sampler
(
   input  wire logic                         clk_in,
   output logic                              valid_out,
   output logic [atd_pkg::CH_W-1:0]          ch_out,
   output logic signed [atd_pkg::SAMP_W-1:0] data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import atd_pkg::*;

   initial begin
      valid_out = 1'b0;
      ch_out    = '0;
      data_out  = '0;
   end
   task automatic send(input logic [CH_W-1:0] ch, input logic signed [SAMP_W-1:0] val);
      @(posedge clk_in);
      valid_out <= 1'b1;
      ch_out    <= ch;
      data_out  <= val;
      @(posedge clk_in);
      valid_out <= 1'b0;
      data_out  <= ~val;
   endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
/*
 Self-checking bench for atd_top.
 Assumes the sampler model and the bound checker.
*/
`default_nettype none
module tb
   import atd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, rst_in, valid, wr_in, rd_in, req, irq;
   logic [CH_W-1:0] ch;
   logic signed [SAMP_W-1:0] data;
   logic [NUM_CH-1:0] flag;
   logic [7:0] addr_in;
   logic [31:0] wdata_in, rdata;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   atd_mode_e mode_t [4] = '{ATD_NORM_SWITCH, ATD_INV_SWITCH, ATD_NORM_WINDOW, ATD_INV_WINDOW};
   int smp [4][5] = '{'{20, 21, 5, -11, 15}, '{-10, -11, 5, 21, 5}, '{5, 21, 18, 16, -11}, '{20, 5, 22, 24, 5}};
   logic [4:0] exp_f [4] = '{5'b00110, 5'b00110, 5'b10110, 5'b10110};

   atd_sampler u_samp (.clk_in(clk_in), .valid_out(valid), .ch_out(ch), .data_out(data));
   atd_top uut (.clk_in(clk_in), .rst_in(rst_in), .samp_valid_in(valid), .samp_ch_in(ch), .samp_data_in(data),
      .samp_req_out(req), .flag_out(flag), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata), .irq_out(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d, errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic samp(input logic [CH_W-1:0] c, input int v, input logic e);
      u_samp.send(c, 16'(v));
      @(posedge clk_in);
      #1 chk(32'(flag[c]), 32'(e));
   endtask

   task automatic t_reset();
      chk({flag, irq}, 9'h000);
      chk(32'(req), 32'h0);
      rd(OFF_SAMP_INT, 32'h01);
      wr(OFF_SAMP_INT, 32'h05);
      rd(OFF_SAMP_INT, 32'h05);
      rd(8'h0c, 32'h0);
      wr(8'h90, 32'hff);
      rd(8'h90, 32'h0);
   endtask
   task automatic t_modes();
      wr(OFF_MASK, 32'hff);
      for (int m = 0; m < 4; m++) begin
         wr(8'(m * 16), {16'h0000, 16'(-10)});
         wr(8'(m * 16 + 4), 32'h14);
         wr(8'(m * 16 + 8), 32'h03);
         wr(8'(m * 16 + 12), {24'h0, 6'h00, mode_t[m]});
         for (int i = 0; i < 5; i++) samp(3'(m), smp[m][i], exp_f[m][i]);
      end
      rd(8'h00, 32'h0000fff6);
      rd(8'h28, 32'h00000003);
      chk(32'(irq), 32'h1);
      rd(OFF_STATUS, 32'h0f);
      chk(32'(irq), 32'h0);
      rd(OFF_FLAGS, 32'h0c);
      wr(OFF_FLAGS, 32'hff);
      rd(OFF_FLAGS, 32'h0c);
   endtask
   task automatic t_mask();
      wr(OFF_MASK, 32'h00);
      samp(3'h0, 21, 1'b1);
      chk(32'(irq), 32'h0);
      rd(OFF_STATUS, 32'h01);
   endtask
   task automatic t_delay();
      wr(8'h44, 32'h14);
      wr(8'h4c, 32'h0500);
      for (int i = 0; i < 3; i++) samp(3'h4, 21, 1'b0);
      wr(8'h4c, 32'hff00);
      rd(8'h4c, 32'hff00);
      wr(8'h4c, 32'h0000);
      samp(3'h4, 21, 1'b1);
   endtask

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      rst_in   = 1'b1;
      addr_in  = '0;
      wdata_in = '0;
      wr_in    = 1'b0;
      rd_in    = 1'b0;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_modes();
      t_mask();
      t_delay();
      finish_test();
   end
endmodule
`default_nettype wire
